//--- pkg/cisf_params.svh
// constants for the control input sampling filter
`ifndef CISF_PARAMS_SVH
`define CISF_PARAMS_SVH

// system clock and time base
`define CISF_CLK_NS          10
`define CISF_BASE_NS         250000
`define CISF_BASE_CYC        (`CISF_BASE_NS / `CISF_CLK_NS)
`define CISF_ALARM_NS        120000000
`define CISF_ALARM_TICKS     (`CISF_ALARM_NS / `CISF_BASE_NS)

// widths
`define CISF_GEN_W           8
`define CISF_TICK_W          16
`define CISF_ALARM_W         9

// setting encodings
`define CISF_CLR_OFF         3'h0
`define CISF_CLR_RAW_LEVEL   3'h1
`define CISF_CLR_FILT_LEVEL  3'h2
`define CISF_CLR_RAW_EDGE    3'h3
`define CISF_CLR_FILT_EDGE   3'h4
`define CISF_ALARM_FIXED     1'h0
`define CISF_INH_VALID       1'h0

// reset values of recognised states
`define CISF_GEN_RST         8'h00
`define CISF_FLAG_RST        1'h0

`endif

//--- pkg/cisf_pkg.sv
// types for the control input sampling filter
package cisf_pkg;

    typedef struct packed {
        logic [1:0] input_filter_select;
        logic       alarm_clear_recognition_select;
        logic [2:0] clear_condition_select;
        logic       inhibit_disable_select;
        logic [2:0] inhibit_sampling_select;
    } cisf_cfg_t;

    typedef struct packed {
        logic [7:0] general_filtered;
        logic       alarm_clear_recognised;
        logic       deviation_clear;
        logic       pulse_inhibit_active;
    } cisf_out_t;

endpackage : cisf_pkg

//--- logic/cisf_filter.sv
// control input sampling filter: sampling, debounce and clear/inhibit conditioning
//
// Summary of operation
// - general inputs sampled at 0.25/0.5/1/2 ms
// - clear and inhibit inputs use own filters
// - alarm clear: 120 ms, or general period
// - clear condition 0 ignores clear input
// - condition 1 raw level, 2 filtered level
// - condition 3 raw edge, 4 filtered edge
// - inhibit honoured only when disable is 0
// - inhibit sampler selects period and count
// - inhibit state changes only when samples agree
`timescale 1ns/10ps
`include "cisf_params.svh"

module cisf_filter #(
    parameter logic [`CISF_TICK_W-1:0] BASE_CYCLES = `CISF_TICK_W'(`CISF_BASE_CYC)
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // settings
    input  wire cisf_pkg::cisf_cfg_t cfg,
    // raw control input pins
    input  wire logic [`CISF_GEN_W-1:0] general_input,
    input  wire logic               alarm_clear_input,
    input  wire logic               deviation_clear_input,
    input  wire logic               pulse_inhibit_input,
    // conditioned outputs
    output cisf_pkg::cisf_out_t     status
);

    localparam int SW = `CISF_GEN_W + 3;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SW-1:0]          sync1_q;
    logic [SW-1:0]          sync2_q;
    logic [`CISF_GEN_W-1:0] gen_s;
    logic                   alm_s;
    logic                   dcl_s;
    logic                   inh_s;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {general_input, alarm_clear_input, deviation_clear_input,
                        pulse_inhibit_input};
            sync2_q <= sync1_q;
        end
    end

    assign gen_s = sync2_q[SW-1:3];
    assign alm_s = sync2_q[2];
    assign dcl_s = sync2_q[1];
    assign inh_s = sync2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // time base: one 0.25 ms tick, longer periods are whole multiples of it
    logic [`CISF_TICK_W-1:0] tick_cnt_q;
    logic [2:0]              div_q;
    logic                    base_tick;

    assign base_tick = (tick_cnt_q == BASE_CYCLES - 1'b1);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_cnt_q <= '0;
            div_q      <= '0;
        end else begin
            tick_cnt_q <= base_tick ? '0 : tick_cnt_q + 1'b1;
            if (base_tick) begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // strobe for period 2^sel base ticks; used by the general and inhibit samplers
    function automatic logic period_hit(input logic [1:0] sel, input logic [2:0] div,
                                        input logic tick);
        logic [2:0] mask;
        mask = 3'((4'h1 << sel) - 4'h1);
        return tick && ((div & mask) == mask);
    endfunction : period_hit

    ////////////////////////////////////////////////////////////////////////////
    // general inputs
    logic                   gen_strobe;
    logic [`CISF_GEN_W-1:0] gen_q;

    assign gen_strobe = period_hit(cfg.input_filter_select, div_q, base_tick);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gen_q <= `CISF_GEN_RST;
        end else if (gen_strobe) begin
            gen_q <= gen_s;
        end
    end

    chk_gen_hold_stable: assert property (@(posedge clk_sys) disable iff (reset)
        !gen_strobe |=> $stable(gen_q))
        else $error("general inputs changed without a sampling strobe");

    chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (reset)
        base_tick |=> !base_tick [*8])
        else $error("base ticks closer than the fixed period");

    ////////////////////////////////////////////////////////////////////////////
    // alarm clear: steady for 120 ms, or sampled like the general inputs
    logic                     alm_q;
    logic [`CISF_ALARM_W-1:0] alm_cnt_q;
    logic                     alm_fixed;
    logic                     alm_done;

    assign alm_fixed = (cfg.alarm_clear_recognition_select == `CISF_ALARM_FIXED);
    assign alm_done  = base_tick &&
                       (alm_cnt_q == `CISF_ALARM_W'(`CISF_ALARM_TICKS - 1));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alm_q     <= `CISF_FLAG_RST;
            alm_cnt_q <= '0;
        end else if (!alm_fixed) begin
            alm_cnt_q <= '0;
            if (gen_strobe) begin
                alm_q <= alm_s;
            end
        end else if (alm_s == alm_q) begin
            alm_cnt_q <= '0;
        end else if (alm_done) begin
            alm_q     <= alm_s;
            alm_cnt_q <= '0;
        end else if (base_tick) begin
            alm_cnt_q <= alm_cnt_q + 1'b1;
        end
    end

    chk_alarm_needs_time: assert property (@(posedge clk_sys) disable iff (reset)
        alm_fixed && $past(alm_fixed) && $changed(alm_q) |-> $past(alm_done))
        else $error("alarm clear recognised before the fixed time");

    ////////////////////////////////////////////////////////////////////////////
    // deviation clear: own filter, two agreeing samples on the base tick
    logic dcl_smp_q;
    logic dcl_filt_q;
    logic dcl_filt_prev_q;
    logic dcl_raw_prev_q;
    logic dcl_out_q;
    logic dcl_d;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dcl_smp_q       <= `CISF_FLAG_RST;
            dcl_filt_q      <= `CISF_FLAG_RST;
            dcl_filt_prev_q <= `CISF_FLAG_RST;
            dcl_raw_prev_q  <= `CISF_FLAG_RST;
            dcl_out_q       <= `CISF_FLAG_RST;
        end else begin
            if (base_tick) begin
                dcl_smp_q <= dcl_s;
                if (dcl_smp_q == dcl_s) begin
                    dcl_filt_q <= dcl_s;
                end
            end
            dcl_filt_prev_q <= dcl_filt_q;
            dcl_raw_prev_q  <= dcl_s;
            dcl_out_q       <= dcl_d;
        end
    end

    // level modes hold clear while active; edge modes give one pulse
    always_comb begin
        case (cfg.clear_condition_select)
            `CISF_CLR_OFF:        dcl_d = 1'b0;
            `CISF_CLR_RAW_LEVEL:  dcl_d = dcl_s;
            `CISF_CLR_FILT_LEVEL: dcl_d = dcl_filt_q;
            `CISF_CLR_RAW_EDGE:   dcl_d = dcl_s && !dcl_raw_prev_q;
            `CISF_CLR_FILT_EDGE:  dcl_d = dcl_filt_q && !dcl_filt_prev_q;
            default:              dcl_d = 1'b0;
        endcase
    end

    chk_clear_off_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.clear_condition_select == `CISF_CLR_OFF |=> !dcl_out_q)
        else $error("deviation clear issued while the input is ignored");

    chk_clear_raw_level: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.clear_condition_select == `CISF_CLR_RAW_LEVEL |=> dcl_out_q == $past(dcl_s))
        else $error("raw level clear does not follow the input");

    chk_clear_filt_level: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.clear_condition_select == `CISF_CLR_FILT_LEVEL
        |=> dcl_out_q == $past(dcl_filt_q))
        else $error("filtered level clear does not follow the filter");

    chk_clear_edge_once: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.clear_condition_select == `CISF_CLR_RAW_EDGE
        && $stable(cfg.clear_condition_select) && dcl_out_q |=> !dcl_out_q)
        else $error("edge clear lasted more than one cycle");

    ////////////////////////////////////////////////////////////////////////////
    // pulse inhibit: period and count of agreeing samples
    logic [1:0] inh_per_sel;
    logic [1:0] inh_need;
    logic       inh_strobe;
    logic [2:0] inh_hist;
    logic [2:0] inh_hist_q;
    logic       inh_agree;
    logic       inh_q;

    assign inh_per_sel = (cfg.inhibit_sampling_select <= 3'h3) ?
                         cfg.inhibit_sampling_select[1:0] : 2'h0;
    assign inh_need    = (cfg.inhibit_sampling_select == 3'h4) ? 2'h1 :
                         (cfg.inhibit_sampling_select == 3'h5) ? 2'h2 : 2'h3;
    assign inh_strobe  = period_hit(inh_per_sel, div_q, base_tick);
    assign inh_hist    = {inh_hist_q[1:0], inh_s};
    // newest sample always counts; older ones only when the count asks for them
    assign inh_agree   = (inh_need < 2'h2 || inh_hist[1] == inh_s) &&
                         (inh_need < 2'h3 || inh_hist[2] == inh_s);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            inh_hist_q <= '0;
            inh_q      <= `CISF_FLAG_RST;
        end else if (inh_strobe) begin
            inh_hist_q <= inh_hist;
            if (inh_agree) begin
                inh_q <= inh_s;
            end
        end
    end

    chk_inh_agree_only: assert property (@(posedge clk_sys) disable iff (reset)
        $changed(inh_q) |-> $past(inh_strobe) && $past(inh_agree))
        else $error("inhibit state changed without agreeing samples");

    chk_inh_ignored: assert property (@(posedge clk_sys) disable iff (reset)
        cfg.inhibit_disable_select != `CISF_INH_VALID |-> !status.pulse_inhibit_active)
        else $error("inhibit asserted while disabled");

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign status.general_filtered       = gen_q;
    assign status.alarm_clear_recognised = alm_q;
    assign status.deviation_clear        = dcl_out_q;
    assign status.pulse_inhibit_active   = inh_q &&
        (cfg.inhibit_disable_select == `CISF_INH_VALID);

endmodule : cisf_filter

//--- bench/cisf_host_model.sv
// host controller model driving the raw control input pins
`timescale 1ns/10ps
module cisf_host_model (
    // clock
    input  wire logic       clk_sys,
    // requested levels: alarm clear, deviation clear, pulse inhibit
    input  wire logic [7:0] gen_req,
    input  wire logic [2:0] ctl_req,
    // pins
    output logic      [7:0] general_input = 8'h00,
    output logic            alarm_clear_input = 1'h0,
    output logic            deviation_clear_input = 1'h0,
    output logic            pulse_inhibit_input = 1'h0
);
    // pins launch one edge after a request, like a host output register;
    // the host holds each level long enough for the chosen period
    always @(posedge clk_sys) begin
        general_input <= gen_req;
        {alarm_clear_input, deviation_clear_input, pulse_inhibit_input} <= ctl_req;
    end
endmodule : cisf_host_model

//--- bench/tb_cisf_filter.sv
// self-checking bench for the control input sampling filter
`timescale 1ns/10ps
module tb_cisf_filter;
    localparam int BC = 10;
    logic                clk_sys = 1'h0;
    logic                reset = 1'h1;
    cisf_pkg::cisf_cfg_t cfg = {2'h0, 1'h0, 3'h3, 1'h1, 3'h0};
    cisf_pkg::cisf_out_t status;
    logic [7:0]          gen_req = 8'h00;
    logic [2:0]          ctl_req = 3'h0;
    logic [7:0]          general_input;
    logic                alarm_clear_input, deviation_clear_input, pulse_inhibit_input;
    int                  n_fail = 0;
    int                  n_checks = 0;
    logic [7:0]          v;
    logic                e, prev;
    int                  p, k, r, n;

    always #5 clk_sys = ~clk_sys;

    cisf_host_model u_cisf_host_model (.clk_sys(clk_sys), .gen_req(gen_req),
        .ctl_req(ctl_req), .general_input(general_input),
        .alarm_clear_input(alarm_clear_input),
        .deviation_clear_input(deviation_clear_input),
        .pulse_inhibit_input(pulse_inhibit_input));
    cisf_filter #(.BASE_CYCLES(16'(BC))) u_cisf_filter (.clk_sys(clk_sys), .reset(reset),
        .cfg(cfg), .general_input(general_input), .alarm_clear_input(alarm_clear_input),
        .deviation_clear_input(deviation_clear_input),
        .pulse_inhibit_input(pulse_inhibit_input), .status(status));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20000);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hc473));
        cyc(3);
        reset <= 1'h0;
        // general period: a change made just after a strobe lands on the next strobe
        for (int s = 0; s < 4; s++) begin
            p = BC << s;
            cfg.input_filter_select <= 2'(s);
            v = status.general_filtered ^ (8'($urandom) | 8'h01);
            gen_req <= v;
            k = 0;
            while (status.general_filtered !== v && k < 100 * p) begin
                cyc(1);
                k++;
            end
            check("general first", status.general_filtered, v);
            gen_req <= ~v;
            cyc(p - 1);
            check("general early", status.general_filtered, v);
            cyc(1);
            check("general late", status.general_filtered, ~v);
        end
        cfg.input_filter_select <= 2'h0;
        cfg.alarm_clear_recognition_select <= 1'h1;
        ctl_req[2] <= 1'h1;
        cyc(30);
        check("alarm general", 8'(status.alarm_clear_recognised), 8'h01);
        cfg.alarm_clear_recognition_select <= 1'h0;
        ctl_req[2] <= 1'h0;
        cyc(470 * BC);
        check("alarm hold", 8'(status.alarm_clear_recognised), 8'h01);
        cyc(10 * BC + 30);
        check("alarm taken", 8'(status.alarm_clear_recognised), 8'h00);
        // slowest general period must not slow the clear and inhibit paths
        cfg.input_filter_select <= 2'h3;
        for (int m = 0; m < 5; m++) begin
            cfg.clear_condition_select <= 3'(m);
            ctl_req[1] <= 1'h0;
            cyc(40);
            ctl_req[1] <= 1'h1;
            e = 1'h0;
            r = 0;
            for (int i = 0; i < 60; i++) begin
                prev = status.deviation_clear;
                cyc(1);
                if (i < 7 && status.deviation_clear === 1'h1) e = 1'h1;
                if (status.deviation_clear === 1'h1 && prev !== 1'h1) r++;
            end
            check("clear early", 8'(e), 8'(m == 1 || m == 3));
            check("clear level", 8'(status.deviation_clear), 8'(m == 1 || m == 2));
            check("clear count", 8'(r), 8'(m != 0));
        end
        cfg.inhibit_disable_select <= 1'h0;
        for (int s = 0; s < 6; s++) begin
            n = s < 4 ? 3 : s - 3;
            p = s < 4 ? BC << s : BC;
            cfg.inhibit_sampling_select <= 3'(s);
            ctl_req[0] <= 1'h0;
            cyc(4 * p + 10);
            check("inhibit idle", 8'(status.pulse_inhibit_active), 8'h00);
            ctl_req[0] <= 1'h1;
            cyc((n - 1) * p + 1);
            check("inhibit early", 8'(status.pulse_inhibit_active), 8'h00);
            cyc(p + 4);
            check("inhibit set", 8'(status.pulse_inhibit_active), 8'h01);
            cfg.inhibit_disable_select <= 1'h1;
            cyc(1);
            check("inhibit off", 8'(status.pulse_inhibit_active), 8'h00);
            cfg.inhibit_disable_select <= 1'h0;
            cyc(1);
        end
        // a short low dip cannot gather three agreeing samples
        cfg.inhibit_sampling_select <= 3'h0;
        ctl_req[0] <= 1'h0;
        cyc(BC);
        ctl_req[0] <= 1'h1;
        cyc(5 * BC);
        check("inhibit dip", 8'(status.pulse_inhibit_active), 8'h01);
        end_of_test();
    end
endmodule : tb_cisf_filter
